// ### include/thermo_pkg.sv
// Notes on behaviour
// RQ1: Hot alarm high while temp at/above upper.
// RQ2: Cold alarm high while temp at/below lower.
// RQ3: Band alarm sets at upper, clears at lower.
// RQ4: Done bit low while converting, else high.
// RQ5: Hot flag sticky, cleared only by writing 0.
// RQ6: Cold flag sticky, cleared only by writing 0.
// RQ7: NV busy reported for nonvolatile write time.
// RQ8: Pin triggers conversions unless host mode set.
// RQ9: Single mode one per start, else continuous.
// RQ10: Alarms hold last completed conversion result.
// RQ11: Serial port always active; host mode blocks trigger.
// RQ12: Short low pulse converts once; held low continuous.
// RQ13: Pin low overrides single conversion mode.
// RQ14: Select frames transfers; low aborts, floats data.
// RQ15: Sample on rise, drive after fall, float high.
// RQ16: Commands and data shift least significant first.
// RQ17: AA, A0, A9 shift out nine data bits.
// RQ18: 01, 02 shift in nine-bit upper/lower limits.
// RQ19: A1, A2 shift out stored limits.
// RQ20: EE starts conversion per selected mode.
// RQ21: 22 finishes current conversion then idles.
// RQ22: 0C writes, AC reads eight config bits.
// RQ23: Nine-bit two's complement, zeros after MSB.
// RQ24: Host waits 10 ms between nonvolatile writes.
// RQ25: Config bits done,hot,cold,busy,1,0,host,single.
package thermo_pkg;

   // =====================================================
   // Timing
   // =====================================================
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned NV_WRITE_MS  = 10;
   localparam int unsigned PULSE_MAX_MS = 10;
   // Longest time: rounded down to whole cycles
   localparam int unsigned NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
   localparam int unsigned PULSE_CYC    = PULSE_MAX_MS * (CLK_HZ / 1000);

   // =====================================================
   // Serial commands
   // =====================================================
   localparam logic [7:0] CMD_READ_TEMP  = 8'hAA;
   localparam logic [7:0] CMD_READ_CNT   = 8'hA0;
   localparam logic [7:0] CMD_READ_SLOPE = 8'hA9;
   localparam logic [7:0] CMD_START_CONV = 8'hEE;
   localparam logic [7:0] CMD_STOP_CONV  = 8'h22;
   localparam logic [7:0] CMD_WRITE_UPR  = 8'h01;
   localparam logic [7:0] CMD_WRITE_LWR  = 8'h02;
   localparam logic [7:0] CMD_READ_UPR   = 8'hA1;
   localparam logic [7:0] CMD_READ_LWR   = 8'hA2;
   localparam logic [7:0] CMD_WRITE_CFG  = 8'h0C;
   localparam logic [7:0] CMD_READ_CFG   = 8'hAC;

   localparam int unsigned CMD_BITS  = 8;
   localparam int unsigned TEMP_BITS = 9;
   localparam int unsigned CFG_BITS  = 8;

   // =====================================================
   // config_status layout and reset values
   // =====================================================
   localparam int unsigned CFG_DONE   = 7;
   localparam int unsigned CFG_HOT    = 6;
   localparam int unsigned CFG_COLD   = 5;
   localparam int unsigned CFG_NVB    = 4;
   localparam int unsigned CFG_ONE    = 3;
   localparam int unsigned CFG_ZERO   = 2;
   localparam int unsigned CFG_HOST   = 1;
   localparam int unsigned CFG_SINGLE = 0;

   localparam logic       HOST_MODE_RST = 1'b0;
   localparam logic       SINGLE_RST    = 1'b0;
   localparam logic [8:0] UPPER_RST     = 9'h000;
   localparam logic [8:0] LOWER_RST     = 9'h000;

   // =====================================================
   // Carriers
   // =====================================================
   typedef struct packed {
      logic hot;
      logic cold;
      logic band;
   } alarm_s;

   typedef struct packed {
      logic host_mode;
      logic single;
   } mode_s;

   typedef enum logic [1:0] {
      SP_CMD,
      SP_WRITE,
      SP_READ,
      SP_IDLE
   } port_state_e;

endpackage

// ### core/pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   input  wire logic [WIDTH-1:0] rst_val_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // =====================================================
   // Sync chain
   // =====================================================
   // The first stage feeds only the second, never logic
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         // Idle levels, so no false edge is seen after reset
         meta_q <= rst_val_i;
         sync_o <= rst_val_i;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule // pin_sync

// ### core/thermostat_3wire_control.sv
`timescale 1ns/1ns
module thermostat_3wire_control #(
   parameter int unsigned NV_WRITE_CYC = thermo_pkg::NV_WRITE_CYC,
   parameter int unsigned PULSE_CYC    = thermo_pkg::PULSE_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       port_select_i,
   input  wire logic       clock_convert_pin_i,
   input  wire logic       serial_io_i,
   output logic            serial_io_o,
   output logic            serial_io_oe_o,
   input  wire logic [8:0] temp_i,
   input  wire logic [8:0] count_remain_i,
   input  wire logic [8:0] slope_i,
   input  wire logic       conv_done_i,
   output logic            conv_start_o,
   output logic            hot_alarm_out_o,
   output logic            cold_alarm_out_o,
   output logic            band_alarm_out_o
);

   localparam int unsigned NVW = $clog2(NV_WRITE_CYC + 1);
   localparam int unsigned PCW = $clog2(PULSE_CYC + 1);

   // =====================================================
   // Elaboration checks
   // =====================================================
   generate
      if (NV_WRITE_CYC < 1 || PULSE_CYC < 1)
      begin : g_bad_param
         $error("Timing counts must be at least one cycle");
      end
   endgenerate

   // =====================================================
   // Pin synchronisers
   // =====================================================
   logic [2:0] pins_s;
   logic       sel_s;
   logic       sck_s;
   logic       dq_s;
   logic       sck_prev_q;
   logic       sck_rise;
   logic       sck_fall;

   pin_sync #(
      .WIDTH (3)
   ) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({port_select_i, clock_convert_pin_i, serial_io_i}),
      .rst_val_i (3'h3), // Select low, clock and data idle high
      .sync_o    (pins_s)
   );

   assign sel_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign dq_s  = pins_s[0];

   // Edge history of the synchronised clock pin
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         sck_prev_q <= 1'b1;
      else
         sck_prev_q <= sck_s;
   end

   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;

   // =====================================================
   // State declarations
   // =====================================================
   thermo_pkg::port_state_e state_q;
   thermo_pkg::alarm_s      alarm_q;
   thermo_pkg::mode_s       mode_q;
   logic [7:0]              cmd_q;
   logic [3:0]              bit_cnt_q;
   logic [3:0]              wr_len_q;
   logic [8:0]              rx_q;
   logic [8:0]              tx_q;
   logic [7:0]              wr_cmd_q;
   logic [8:0]              upper_q;
   logic [8:0]              lower_q;
   logic [8:0]              temp_q;
   logic                    hot_flag_q;
   logic                    cold_flag_q;
   logic [NVW-1:0]          nv_cnt_q;
   logic                    nv_busy;
   logic                    run_q;
   logic                    one_q;
   logic                    pend_q;
   logic                    busy_q;
   logic [PCW-1:0]          low_cnt_q;
   logic                    pin_held;
   logic                    start_cmd;
   logic                    stop_cmd;
   logic                    cfg_wr;
   logic                    lim_wr;
   logic [7:0]              cfg_rd;
   logic                    alone;
   logic                    upr_hit;
   logic                    lwr_hit;

   // Signed compare of nine-bit half-degree values
   function automatic logic ge9(input logic [8:0] a, input logic [8:0] b);
      ge9 = $signed(a) >= $signed(b); // [RQ23]
   endfunction

   assign nv_busy = (nv_cnt_q != '0);
   assign upr_hit = ge9(temp_i, upper_q);
   assign lwr_hit = ge9(lower_q, temp_i);

   // Readback image of config_status
   always_comb
   begin
      cfg_rd                         = 8'h00;
      cfg_rd[thermo_pkg::CFG_DONE]   = ~busy_q;        // [RQ4]
      cfg_rd[thermo_pkg::CFG_HOT]    = hot_flag_q;
      cfg_rd[thermo_pkg::CFG_COLD]   = cold_flag_q;
      cfg_rd[thermo_pkg::CFG_NVB]    = nv_busy;        // [RQ7]
      cfg_rd[thermo_pkg::CFG_ONE]    = 1'b1;           // [RQ25]
      cfg_rd[thermo_pkg::CFG_ZERO]   = 1'b0;
      cfg_rd[thermo_pkg::CFG_HOST]   = mode_q.host_mode;
      cfg_rd[thermo_pkg::CFG_SINGLE] = mode_q.single;
   end

   // =====================================================
   // Serial command port
   // =====================================================
   // Select low aborts everything and floats the data pin; the port
   // works whatever host mode says
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || !sel_s) // [RQ14] [RQ11]
      begin
         state_q        <= thermo_pkg::SP_CMD;
         cmd_q          <= 8'h00;
         bit_cnt_q      <= 4'h0;
         wr_len_q       <= 4'h0;
         rx_q           <= 9'h000;
         tx_q           <= 9'h000;
         wr_cmd_q       <= 8'h00;
         serial_io_o    <= 1'b0;
         serial_io_oe_o <= 1'b0;
      end
      else
      begin
         case (state_q)
            thermo_pkg::SP_CMD:
            begin
               if (sck_rise)
               begin
                  cmd_q     <= {dq_s, cmd_q[7:1]}; // [RQ16] [RQ15]
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == 4'(thermo_pkg::CMD_BITS - 1))
                  begin
                     bit_cnt_q <= 4'h0;
                     state_q   <= thermo_pkg::SP_IDLE;
                     case ({dq_s, cmd_q[7:1]})
                        thermo_pkg::CMD_READ_TEMP:
                        begin
                           tx_q    <= temp_q;          // [RQ17]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_READ_CNT:
                        begin
                           tx_q    <= count_remain_i;  // [RQ17]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_READ_SLOPE:
                        begin
                           tx_q    <= slope_i;         // [RQ17]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_READ_UPR:
                        begin
                           tx_q    <= upper_q;         // [RQ19]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_READ_LWR:
                        begin
                           tx_q    <= lower_q;         // [RQ19]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_READ_CFG:
                        begin
                           tx_q    <= {1'b0, cfg_rd};  // [RQ22]
                           state_q <= thermo_pkg::SP_READ;
                        end
                        thermo_pkg::CMD_WRITE_UPR,
                        thermo_pkg::CMD_WRITE_LWR:
                        begin
                           wr_cmd_q <= {dq_s, cmd_q[7:1]}; // [RQ18]
                           wr_len_q <= 4'(thermo_pkg::TEMP_BITS);
                           state_q  <= thermo_pkg::SP_WRITE;
                        end
                        thermo_pkg::CMD_WRITE_CFG:
                        begin
                           wr_cmd_q <= thermo_pkg::CMD_WRITE_CFG;
                           wr_len_q <= 4'(thermo_pkg::CFG_BITS); // [RQ22]
                           state_q  <= thermo_pkg::SP_WRITE;
                        end
                        default:
                           state_q <= thermo_pkg::SP_IDLE;
                     endcase
                  end
               end
            end
            thermo_pkg::SP_WRITE:
            begin
               if (sck_rise)
               begin
                  rx_q      <= {dq_s, rx_q[8:1]}; // [RQ16]
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == wr_len_q - 4'h1)
                     state_q <= thermo_pkg::SP_IDLE;
               end
            end
            thermo_pkg::SP_READ:
            begin
               // Drive after the fall, let go once the clock is high
               if (sck_fall)
               begin
                  serial_io_o    <= tx_q[0];           // [RQ15] [RQ16]
                  serial_io_oe_o <= 1'b1;
                  tx_q           <= {1'b0, tx_q[8:1]}; // [RQ23]
               end
               else if (sck_rise)
                  serial_io_oe_o <= 1'b0;              // [RQ15]
            end
            thermo_pkg::SP_IDLE:
               serial_io_oe_o <= 1'b0;
            default:
               state_q <= thermo_pkg::SP_CMD;
         endcase
      end
   end

   // One-cycle command strobes, taken at the last bit
   assign start_cmd = sel_s && sck_rise && state_q == thermo_pkg::SP_CMD
                      && bit_cnt_q == 4'(thermo_pkg::CMD_BITS - 1)
                      && {dq_s, cmd_q[7:1]} == thermo_pkg::CMD_START_CONV;
   assign stop_cmd  = sel_s && sck_rise && state_q == thermo_pkg::SP_CMD
                      && bit_cnt_q == 4'(thermo_pkg::CMD_BITS - 1)
                      && {dq_s, cmd_q[7:1]} == thermo_pkg::CMD_STOP_CONV;
   assign cfg_wr    = sel_s && sck_rise && state_q == thermo_pkg::SP_WRITE
                      && bit_cnt_q == wr_len_q - 4'h1
                      && wr_cmd_q == thermo_pkg::CMD_WRITE_CFG;
   assign lim_wr    = sel_s && sck_rise && state_q == thermo_pkg::SP_WRITE
                      && bit_cnt_q == wr_len_q - 4'h1
                      && wr_cmd_q != thermo_pkg::CMD_WRITE_CFG;

   // =====================================================
   // Nonvolatile store
   // =====================================================
   // Limits and mode bits land at once; the busy window only models
   // the cell write time, so early writes are not refused
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         upper_q          <= thermo_pkg::UPPER_RST;
         lower_q          <= thermo_pkg::LOWER_RST;
         mode_q.host_mode <= thermo_pkg::HOST_MODE_RST; // [RQ8]
         mode_q.single    <= thermo_pkg::SINGLE_RST;    // [RQ9]
      end
      else if (lim_wr)
      begin
         if (wr_cmd_q == thermo_pkg::CMD_WRITE_UPR)
            upper_q <= {dq_s, rx_q[8:1]};               // [RQ18]
         else
            lower_q <= {dq_s, rx_q[8:1]};               // [RQ18]
      end
      else if (cfg_wr)
      begin
         mode_q.host_mode <= rx_q[thermo_pkg::CFG_HOST + 2];   // [RQ22]
         mode_q.single    <= rx_q[thermo_pkg::CFG_SINGLE + 2];
      end
   end

   // Busy window after any nonvolatile write
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         nv_cnt_q <= '0;
      else if (lim_wr || cfg_wr)
         nv_cnt_q <= NVW'(NV_WRITE_CYC);   // [RQ7] [RQ24]
      else if (nv_busy)
         nv_cnt_q <= nv_cnt_q - NVW'(1);
   end

   // =====================================================
   // Stand-alone trigger
   // =====================================================
   assign alone    = ~mode_q.host_mode & ~sel_s;           // [RQ8] [RQ11]
   assign pin_held = alone & ~sck_s
                     & (low_cnt_q == PCW'(PULSE_CYC));     // [RQ12]

   // Measure how long the pin has stayed low
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || !alone || sck_s)
         low_cnt_q <= '0;
      else if (low_cnt_q != PCW'(PULSE_CYC))
         low_cnt_q <= low_cnt_q + PCW'(1);
   end

   // =====================================================
   // Conversion sequencing
   // =====================================================
   // Pin fall queues one conversion whatever single mode says
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         pend_q <= 1'b0;
      else if (alone && sck_fall)
         pend_q <= 1'b1;                         // [RQ12] [RQ13]
      else if (conv_start_o)
         pend_q <= 1'b0;
   end

   // Continuous run flag and one-shot request from the port
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         run_q <= 1'b0;
         one_q <= 1'b0;
      end
      else if (start_cmd)
      begin
         run_q <= ~mode_q.single;                // [RQ20] [RQ9]
         one_q <= mode_q.single;
      end
      else if (stop_cmd)
      begin
         run_q <= 1'b0;                          // [RQ21]
         one_q <= 1'b0;
      end
      else if (conv_start_o)
         one_q <= 1'b0;
   end

   // Current conversion always finishes before the next decision
   assign conv_start_o = ~busy_q & (run_q | one_q | pend_q | pin_held);

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         busy_q <= 1'b0;
      else if (conv_start_o)
         busy_q <= 1'b1;                         // [RQ4]
      else if (conv_done_i)
         busy_q <= 1'b0;                         // [RQ21]
   end

   // =====================================================
   // Result, alarms and sticky flags
   // =====================================================
   // Alarms move only on a finished conversion, so they hold between
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         temp_q  <= 9'h000;
         alarm_q <= '0;
      end
      else if (busy_q && conv_done_i)            // [RQ10]
      begin
         temp_q       <= temp_i;
         alarm_q.hot  <= upr_hit;                // [RQ1]
         alarm_q.cold <= lwr_hit;                // [RQ2]
         if (upr_hit)
            alarm_q.band <= 1'b1;                // [RQ3]
         else if (lwr_hit)
            alarm_q.band <= 1'b0;                // [RQ3]
      end
   end

   // A set in the clearing cycle wins over the clear
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         hot_flag_q  <= 1'b0;
         cold_flag_q <= 1'b0;
      end
      else
      begin
         if (busy_q && conv_done_i && upr_hit)
            hot_flag_q <= 1'b1;                  // [RQ5]
         else if (cfg_wr && !rx_q[thermo_pkg::CFG_HOT + 2])
            hot_flag_q <= 1'b0;                  // [RQ5]
         if (busy_q && conv_done_i && lwr_hit)
            cold_flag_q <= 1'b1;                 // [RQ6]
         else if (cfg_wr && !rx_q[thermo_pkg::CFG_COLD + 2])
            cold_flag_q <= 1'b0;                 // [RQ6]
      end
   end

   assign hot_alarm_out_o  = alarm_q.hot;
   assign cold_alarm_out_o = alarm_q.cold;
   assign band_alarm_out_o = alarm_q.band;

endmodule // thermostat_3wire_control

// ### verif/host_model.sv
`timescale 1ns/1ns
// ==========================================
// Host controller on the three-wire port
module host_model (
   input  wire logic dev_io_i,
   input  wire logic dev_oe_i,
   output logic      sel_o,
   output logic      clk_o,
   output logic      wire_o
);
   logic drv_q = 1'b0;
   logic bit_q = 1'b0;
   // Data line has a pull-up, so a released line reads high
   assign wire_o = dev_oe_i ? dev_io_i : (drv_q ? bit_q : 1'b1);
   initial
   begin
      sel_o = 1'b0;
      clk_o = 1'b1;
   end
   // One frame: command, then nb data bits; link clock idles high
   task automatic xfer(input logic [7:0] cmd, input int nb,
      input logic [8:0] wd, input bit rd, output logic [8:0] rv);
      logic [16:0] sh;
      sh = {wd, cmd};
      rv = 9'h000;
      sel_o = 1'b1;
      #100;
      for (int i = 0; i < 8 + nb; i++)
      begin
         #62 clk_o = 1'b0;
         drv_q = !(rd && i >= 8);
         bit_q = sh[i];
         #63;
         if (i >= 8)
            rv[i-8] = wire_o;
         clk_o = 1'b1;
      end
      #62 drv_q = 1'b0;
      sel_o = 1'b0;
      #200;
   endtask
   // Stand-alone trigger: pin held low for ns, select low
   task automatic pulse(input int ns);
      #50 clk_o = 1'b0;
      #(ns);
      clk_o = 1'b1;
      #300;
   endtask
endmodule // host_model

// ### verif/thermostat_3wire_control_sva.sv
`timescale 1ns/1ns
module thermostat_3wire_control_sva (
   input  wire logic mclk_i,
   input  wire logic sys_rst_i,
   input  wire logic port_select_i,
   input  wire logic clock_convert_pin_i,
   input  wire logic serial_io_o,
   input  wire logic serial_io_oe_o,
   input  wire logic conv_done_i,
   input  wire logic conv_start_o,
   input  wire logic hot_alarm_out_o,
   input  wire logic cold_alarm_out_o,
   input  wire logic band_alarm_out_o
);
   logic busy_q;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================
   // Converter occupancy from the start/done handshake
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || conv_done_i)
         busy_q <= 1'b0;
      else if (conv_start_o)
         busy_q <= 1'b1;
   end
   a_sel_low_float: assert property (
      (!port_select_i)[*5] |-> !serial_io_oe_o)
      else $error("data line driven with select low");
   a_cmd_quiet: assert property (
      $rose(port_select_i) |=> (!serial_io_oe_o)[*8])
      else $error("data line driven during command");
   a_clk_high_float: assert property (
      clock_convert_pin_i[*6] |-> !serial_io_oe_o)
      else $error("data line driven while clock high");
   a_drive_on_low: assert property (
      $rose(serial_io_oe_o) |-> !$past(clock_convert_pin_i))
      else $error("drive started while clock high");
   a_bit_stands: assert property (
      serial_io_oe_o && $past(serial_io_oe_o) |-> $stable(serial_io_o))
      else $error("read bit changed while driven");
   a_alarm_hold: assert property (
      !conv_done_i && !$past(conv_done_i) |=>
      $stable({hot_alarm_out_o, cold_alarm_out_o, band_alarm_out_o}))
      else $error("alarm moved without a conversion");
   a_hot_in_band: assert property (
      hot_alarm_out_o |-> band_alarm_out_o)
      else $error("hot alarm without band alarm");
   a_one_start: assert property (
      busy_q |-> !conv_start_o)
      else $error("start while converting");
endmodule // thermostat_3wire_control_sva
bind thermostat_3wire_control thermostat_3wire_control_sva u_sva (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .port_select_i(port_select_i),
   .clock_convert_pin_i(clock_convert_pin_i), .serial_io_o(serial_io_o),
   .serial_io_oe_o(serial_io_oe_o), .conv_done_i(conv_done_i),
   .conv_start_o(conv_start_o), .hot_alarm_out_o(hot_alarm_out_o),
   .cold_alarm_out_o(cold_alarm_out_o),
   .band_alarm_out_o(band_alarm_out_o));

// ### verif/thermostat_3wire_control_tb.sv
`timescale 1ns/1ns
module thermostat_3wire_control_tb;
   logic               mclk_i;
   logic               sys_rst_i = 1'b1;
   logic               sel;
   logic               cpin;
   logic               io_wire;
   logic               io_o;
   logic               io_oe;
   logic               start;
   logic               done_q = 1'b0;
   logic [8:0]         temp_q = 9'h000;
   logic [8:0]         rv;
   logic [8:0]         cnt_q = 9'h1A5;
   logic [8:0]         slope_q = 9'h05A;
   thermo_pkg::alarm_s al;
   int                 wait_q = 0;
   int                 nstart = 0;
   int                 n0;
   int                 cyc = 0;
   int                 miscompares = 0;
   int                 checked = 0;
   logic [8:0] temps [5] = '{9'h060, 9'h030, 9'h1CE, 9'h0FA, 9'h014};
   logic [2:0] alarms [5] = '{3'h5, 3'h1, 3'h2, 3'h5, 3'h2};
   // Small limit-write delay keeps the busy window short in sim
   thermostat_3wire_control #(.NV_WRITE_CYC(2000), .PULSE_CYC(40)) u_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .port_select_i(sel),
      .clock_convert_pin_i(cpin), .serial_io_i(io_wire),
      .serial_io_o(io_o), .serial_io_oe_o(io_oe), .temp_i(temp_q),
      .count_remain_i(cnt_q), .slope_i(slope_q), .conv_done_i(done_q),
      .conv_start_o(start), .hot_alarm_out_o(al.hot),
      .cold_alarm_out_o(al.cold), .band_alarm_out_o(al.band));
   host_model u_host (.dev_io_i(io_o), .dev_oe_i(io_oe), .sel_o(sel),
      .clk_o(cpin), .wire_o(io_wire));
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // ==========================================
   // Converter stand-in: done 20 cycles after start; hang guard
   always @(posedge mclk_i)
   begin
      #1; // Start is combinational: look once it has settled
      cyc <= cyc + 1;
      nstart <= nstart + int'(start);
      done_q <= (wait_q == 1);
      wait_q <= start ? 20 : (wait_q > 0 ? wait_q - 1 : 0);
      if (cyc == 60000)
      begin
         miscompares++;
         summarize();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [8:0] e,
      input logic [8:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdv(input logic [7:0] c, input int nb,
      input logic [8:0] e);
      u_host.xfer(c, nb, 9'h000, 1'b1, rv);
      chk($sformatf("read %h", c), e, rv);
   endtask
   // Every nonvolatile write waits out the busy time
   task automatic wrv(input logic [7:0] c, input int nb,
      input logic [8:0] d);
      u_host.xfer(c, nb, d, 1'b0, rv);
      tick(2100);
   endtask
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      tick(5);
      sys_rst_i = 1'b0;
      tick(5);
      rdv(8'hAC, 8, 9'h088);
      u_host.xfer(8'h01, 9, 9'h050, 1'b0, rv);
      rdv(8'hAC, 8, 9'h098);
      tick(2100);
      wrv(8'h02, 9, 9'h014);
      rdv(8'hA1, 9, 9'h050);
      rdv(8'hA2, 9, 9'h014);
      wrv(8'h0C, 8, 9'h001);
      rdv(8'hA0, 9, 9'h1A5);
      rdv(8'hA9, 9, 9'h05A);
      $display("serial test done");
      foreach (temps[i])
      begin
         tick(1);
         temp_q = temps[i];
         n0 = nstart;
         u_host.xfer(8'hEE, 0, 9'h000, 1'b0, rv);
         tick(60);
         chk("starts", 9'h001, 9'(nstart - n0));
         chk("alarms", {6'h00, alarms[i]}, {6'h00, al});
         rdv(8'hAA, 9, temps[i]);
      end
      rdv(8'hAC, 8, 9'h0E9);
      wrv(8'h0C, 8, 9'h001);
      rdv(8'hAC, 8, 9'h089);
      $display("thermostat test done");
      n0 = nstart;
      u_host.pulse(200);
      tick(60);
      chk("pulse", 9'h001, 9'(nstart - n0));
      n0 = nstart;
      u_host.pulse(1500);
      tick(60);
      chk("held", 9'h001, 9'(nstart - n0 >= 4));
      wrv(8'h0C, 8, 9'h003);
      n0 = nstart;
      u_host.pulse(200);
      tick(60);
      chk("host pulse", 9'h000, 9'(nstart - n0));
      wrv(8'h0C, 8, 9'h002);
      n0 = nstart;
      u_host.xfer(8'hEE, 0, 9'h000, 1'b0, rv);
      tick(200);
      chk("run", 9'h001, 9'(nstart - n0 >= 5));
      u_host.xfer(8'h22, 0, 9'h000, 1'b0, rv);
      tick(60);
      n0 = nstart;
      tick(200);
      chk("stopped", 9'h000, 9'(nstart - n0));
      u_host.xfer(8'hAA, 4, 9'h000, 1'b1, rv);
      rdv(8'hAA, 9, 9'h014);
      $display("conversion test done");
      summarize();
   end
endmodule // thermostat_3wire_control_tb
